// *** design/hub_cfg_pkg.sv ***
package hub_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RELEASE_LOW  = 8'h04;
  localparam logic [7:0] ADDR_RELEASE_HIGH = 8'h05;
  localparam logic [7:0] ADDR_CONFIG_ONE   = 8'h06;
  localparam logic [7:0] ADDR_CONFIG_TWO   = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POWER_SOURCE_BIT = 7;
  localparam int unsigned RESERVED_BIT     = 6;
  localparam int unsigned HS_BLOCK_BIT     = 5;
  localparam int unsigned TRANSLATOR_BIT   = 4;
  localparam int unsigned AUTO_POWER_BIT   = 7;

  // Writable bits of configuration byte 1 handled here (bit 6 reserved)
  localparam logic [7:0] CONFIG_ONE_MASK = 8'hb0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RELEASE_RESET    = 8'h00;
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;

endpackage : hub_cfg_pkg

// *** design/hub_cfg_bus_if.sv ***
`timescale 1ns/10ps
interface hub_cfg_bus_if;
  import hub_cfg_pkg::*;

  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport master (output wr_en, output addr, output wdata, input rdata);
  modport slave  (input wr_en, input addr, input wdata, output rdata);
endinterface : hub_cfg_bus_if

// *** design/hub_cfg_store.sv ***
`timescale 1ns/10ps
module hub_cfg_store
  import hub_cfg_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  input  wire logic   i_ce,
  hub_cfg_bus_if.slave bus,
  output logic [7:0]  o_config_one,
  output logic [7:0]  o_config_two
);

  typedef struct packed {
    logic [7:0] rel_low;
    logic [7:0] rel_high;
    logic [7:0] hub_config_byte_one;
    logic [7:0] cfg2;
    logic [7:0] rdata;
  } store_t;

  store_t state;
  store_t next_state;

  // Write decode and registered read mux
  always_comb
  begin
    next_state = state;
    if (bus.wr_en)
    begin
      case (bus.addr)
        ADDR_RELEASE_LOW:  next_state.rel_low  = bus.wdata;
        ADDR_RELEASE_HIGH: next_state.rel_high = bus.wdata;
        ADDR_CONFIG_ONE:   next_state.hub_config_byte_one = bus.wdata & CONFIG_ONE_MASK;
        ADDR_CONFIG_TWO:   next_state.cfg2 = bus.wdata;
        default:           next_state.cfg2 = state.cfg2;
      endcase
    end
    // Read data registered so the answer comes one cycle after the address
    case (bus.addr)
      ADDR_RELEASE_LOW:  next_state.rdata = next_state.rel_low;
      ADDR_RELEASE_HIGH: next_state.rdata = next_state.rel_high;
      ADDR_CONFIG_ONE:   next_state.rdata = next_state.hub_config_byte_one;
      ADDR_CONFIG_TWO:   next_state.rdata = next_state.cfg2;
      default:           next_state.rdata = READ_ZERO;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state.rel_low  <= RELEASE_RESET;
      state.rel_high <= RELEASE_RESET;
      state.hub_config_byte_one     <= CONFIG_ONE_RESET;
      state.cfg2     <= CONFIG_TWO_RESET;
      state.rdata    <= READ_ZERO;
    end
    else if (i_ce)
    begin
      state <= next_state;
    end
  end

  assign bus.rdata    = state.rdata;
  assign o_config_one = state.hub_config_byte_one;
  assign o_config_two = state.cfg2;

  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !state.hub_config_byte_one[RESERVED_BIT]) else $error("reserved bit set");

endmodule : hub_cfg_store

// *** design/hub_release_and_config_regs.sv ***
`timescale 1ns/10ps
module hub_release_and_config_regs
  import hub_cfg_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_reg_wr_en,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_host_single_translator,
  input  wire logic        i_suspended,
  input  wire logic        i_power_pin_in,
  output logic      [7:0]  o_reg_rdata,
  output logic      [15:0] o_release_number,
  output logic             o_self_powered,
  output logic             o_high_speed_block,
  output logic             o_per_port_translator,
  output logic             o_power_pin_out,
  output logic             o_power_pin_oe
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  hub_cfg_bus_if bus ();
  logic [7:0] config_one;
  logic [7:0] config_two;

  // Bus pins reach the store through the interface; the top keeps plain ports
  assign bus.wr_en = i_reg_wr_en;
  assign bus.addr  = i_reg_addr;
  assign bus.wdata = i_reg_wdata;

  hub_cfg_store u_store (
    .i_clk        (i_clk),
    .i_resetn     (i_resetn),
    .i_ce         (i_ce),
    .bus          (bus),
    .o_config_one (config_one),
    .o_config_two (config_two)
  );

  // ----------------------------------------------------------------
  // Derived mode outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  rdata;
    logic [15:0] release_number;
    logic        self_powered;
    logic        hs_block;
    logic        per_port;
    logic        pin_out;
    logic        pin_oe;
  } out_t;

  out_t state;
  out_t next_state;
  logic auto_power;

  // Shared write decode for the two release byte lanes
  function automatic logic write_hits(input logic       wr_en,
                                      input logic [7:0] addr,
                                      input logic [7:0] target);
    return wr_en && (addr == target);
  endfunction : write_hits

  // Release bytes are tracked here too so the 16-bit value comes from a flop
  always_comb
  begin
    next_state = state;
    auto_power = config_two[AUTO_POWER_BIT];
    // One more flop on read data so the port is a register output; costs a cycle
    next_state.rdata = bus.rdata;
    // Byte writes land here on the same edge as in the store, so both copies agree
    if (write_hits(i_reg_wr_en, i_reg_addr, ADDR_RELEASE_LOW))
      next_state.release_number[7:0] = i_reg_wdata;
    if (write_hits(i_reg_wr_en, i_reg_addr, ADDR_RELEASE_HIGH))
      next_state.release_number[15:8] = i_reg_wdata;
    // Auto switching ignores the stored power bit
    next_state.self_powered = auto_power ? i_power_pin_in
                                         : config_one[POWER_SOURCE_BIT];
    next_state.hs_block = config_one[HS_BLOCK_BIT];
    next_state.per_port = config_one[TRANSLATOR_BIT]
                          && !i_host_single_translator;
    // Shared pin: input while auto power on, suspend indicator otherwise
    next_state.pin_oe  = !auto_power;
    next_state.pin_out = !auto_power && i_suspended;
  end

  // Enable low freezes every output together with the store
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= '0;
    end
    else if (i_ce)
    begin
      state <= next_state;
    end
  end

  // Each output is a bit of the registered state, never a gate after it
  assign o_reg_rdata           = state.rdata;
  assign o_release_number      = state.release_number;
  assign o_self_powered        = state.self_powered;
  assign o_high_speed_block    = state.hs_block;
  assign o_per_port_translator = state.per_port;
  assign o_power_pin_out       = state.pin_out;
  assign o_power_pin_oe        = state.pin_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A byte written with enable high, then its address held for one more enabled cycle
  // (the write is taken, then the forwarded byte climbs the two read flops)
  sequence s_write_held(logic [7:0] target);
    i_ce && i_reg_wr_en && i_reg_addr == target
    ##1 i_ce && !i_reg_wr_en && i_reg_addr == target;
  endsequence : s_write_held

  // Configuration byte 1 addressed, then one more enabled cycle to reach the port
  sequence s_config_one_read;
    i_ce && i_reg_addr == ADDR_CONFIG_ONE
    ##1 i_ce;
  endsequence : s_config_one_read

  // Release number copy follows each byte write one edge later
  a_release_low_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_reg_wr_en && i_reg_addr == ADDR_RELEASE_LOW
    |=> o_release_number[7:0] == $past(i_reg_wdata))
    else $error("low byte lost");
  a_release_high_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_reg_wr_en && i_reg_addr == ADDR_RELEASE_HIGH
    |=> o_release_number[15:8] == $past(i_reg_wdata))
    else $error("high byte lost");
  a_release_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !(i_reg_wr_en && (i_reg_addr == ADDR_RELEASE_LOW || i_reg_addr == ADDR_RELEASE_HIGH))
    |=> $stable(o_release_number))
    else $error("release moved");

  // Readback compares with the written byte, not with the store's output, so a
  // broken store or a dropped forward path is caught as well
  a_release_readback: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_write_held(ADDR_RELEASE_HIGH)
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("readback wrong");
  a_low_readback: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_write_held(ADDR_RELEASE_LOW)
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("low readback wrong");

  // Power source: stored bit when manual, supply pin when auto switching
  // Auto switching must ignore the stored bit entirely
  a_power_manual: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !config_two[AUTO_POWER_BIT]
    |=> o_self_powered == $past(config_one[POWER_SOURCE_BIT]))
    else $error("power bit");
  a_power_auto: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && config_two[AUTO_POWER_BIT]
    |=> o_self_powered == $past(i_power_pin_in))
    else $error("supply pin");

  // Speed selection follows the stored bit
  a_speed_block: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce
    |=> o_high_speed_block == $past(config_one[HS_BLOCK_BIT]))
    else $error("speed");

  // Per-port translators only while the stored bit is set and the host allows it
  a_translator_mode: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && config_one[TRANSLATOR_BIT] && !i_host_single_translator
    |=> o_per_port_translator)
    else $error("translator");
  a_translator_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !config_one[TRANSLATOR_BIT]
    |=> !o_per_port_translator)
    else $error("translator off");
  a_host_single: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_host_single_translator
    |=> !o_per_port_translator)
    else $error("host tt");

  // Shared pin: driven as suspend indicator only while auto switching is off
  // Released pin must not be driven, or it fights the supply-present signal
  a_pin_direction: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce
    |=> o_power_pin_oe == !$past(config_two[AUTO_POWER_BIT]))
    else $error("pin dir");
  a_pin_suspend_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && !config_two[AUTO_POWER_BIT]
    |=> o_power_pin_out == $past(i_suspended))
    else $error("suspend out");
  a_pin_released_auto: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && config_two[AUTO_POWER_BIT]
    |=> !o_power_pin_oe && !o_power_pin_out)
    else $error("pin released");

  // Reserved bit never reaches the read port, whatever was written to it
  a_reserved_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_config_one_read
    |=> !o_reg_rdata[RESERVED_BIT])
    else $error("reserved read");

  // Enable low holds every output; a stray update here would move the hub's
  // attach mode while the loader has paused it
  a_enable_freeze: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_ce
    |=> $stable(o_reg_rdata) && $stable(o_release_number) && $stable(o_self_powered)
        && $stable(o_high_speed_block) && $stable(o_per_port_translator)
        && $stable(o_power_pin_out) && $stable(o_power_pin_oe))
    else $error("enable freeze");

endmodule : hub_release_and_config_regs

// *** test/cfg_loader_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Configuration loader standing in for the external bus master
// ----------------------------------------------------------------
module cfg_loader_model
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // Idle values at time zero
  initial
  begin
    o_wr_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // One-cycle write strobe, then one idle edge so a following write never raises
  // the strobe in the time step that lowered it; data inverted so stale data shows
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    o_wdata = ~d;
    @(posedge i_clk);
    #1;
  endtask : write_reg

  // Address held for three edges, longer than the two-edge read latency
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    repeat (3) @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask : read_reg
endmodule : cfg_loader_model

// *** test/hub_release_and_config_regs_tb.sv ***
`timescale 1ns/10ps
module hub_release_and_config_regs_tb;
  import hub_cfg_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_ce = 1'b1;
  logic        single_tt = 1'b0;
  logic        suspended = 1'b0;
  logic        pin_in = 1'b0;
  logic        wr_en;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  rd;
  logic [15:0] rel;
  logic        self_pwr, hs_blk, ppt, pin_out, pin_oe;
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #5 i_clk = ~i_clk;

  cfg_loader_model host (.i_clk(i_clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_addr(addr),
    .o_wdata(wdata));

  hub_release_and_config_regs dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_reg_wr_en(wr_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_host_single_translator(single_tt), .i_suspended(suspended),
    .i_power_pin_in(pin_in), .o_reg_rdata(rdata), .o_release_number(rel),
    .o_self_powered(self_pwr), .o_high_speed_block(hs_blk),
    .o_per_port_translator(ppt), .o_power_pin_out(pin_out), .o_power_pin_oe(pin_oe));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Mode outputs settle two edges after a register write, one after a pin change; three are waited
  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle

  // Hang guard well beyond the roughly 80 cycles the sequence needs
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    settle();
    chk("modes", 16'h0001, {self_pwr, hs_blk, ppt, pin_out, pin_oe});
    for (int a = 4; a < 8; a++)
    begin
      host.read_reg(8'(a), rd);
      chk("reset read", 16'h0000, rd);
    end
    host.write_reg(8'h04, 8'h34);
    host.write_reg(8'h05, 8'h12);
    chk("release", 16'h1234, rel);
    i_ce = 1'b0;
    host.write_reg(8'h04, 8'h55);
    chk("release frozen", 16'h1234, rel);
    i_ce = 1'b1;
    host.read_reg(8'h04, rd);
    chk("low byte", 16'h0034, rd);
    host.read_reg(8'h05, rd);
    chk("high byte", 16'h0012, rd);
    host.write_reg(ADDR_CONFIG_ONE, 8'hff);
    settle();
    chk("modes", 16'h001d, {self_pwr, hs_blk, ppt, pin_out, pin_oe});
    host.read_reg(ADDR_CONFIG_ONE, rd);
    chk("config one", 16'h00b0, rd);
    single_tt = 1'b1;
    settle();
    chk("translator", 16'h0000, ppt);
    suspended = 1'b1;
    settle();
    chk("modes", 16'h001b, {self_pwr, hs_blk, ppt, pin_out, pin_oe});
    host.write_reg(ADDR_CONFIG_TWO, 8'h80);
    settle();
    chk("self pin low", 16'h0000, {self_pwr, pin_oe});
    host.read_reg(ADDR_CONFIG_TWO, rd);
    chk("config two", 16'h0080, rd);
    pin_in = 1'b1;
    host.write_reg(ADDR_CONFIG_ONE, 8'h00);
    settle();
    chk("self pin high", 16'h0001, self_pwr);
    host.write_reg(ADDR_CONFIG_TWO, 8'h00);
    settle();
    chk("modes", 16'h0003, {self_pwr, hs_blk, ppt, pin_out, pin_oe});
    host.write_reg(8'h08, 8'hff);
    host.read_reg(8'h08, rd);
    chk("unmapped", 16'h0000, rd);
    host.read_reg(8'h04, rd);
    chk("low byte", 16'h0034, rd);
    // Mid-run reset must bring the stored selections and release bytes back to zero
    host.write_reg(ADDR_CONFIG_ONE, 8'hb0);
    i_resetn = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    settle();
    chk("reset modes", 16'h0003, {self_pwr, hs_blk, ppt, pin_out, pin_oe});
    chk("reset release", 16'h0000, rel);
    host.read_reg(ADDR_CONFIG_ONE, rd);
    chk("reset config one", 16'h0000, rd);
    close_out();
  end
endmodule : hub_release_and_config_regs_tb
